// ### verilog/adex_pkg.sv
// shared constants, field layouts and types of the descriptor launcher
package adex_pkg;
  // software-facing register byte offsets
  localparam logic [4:0] ADEX_REG_CTRL = 5'h00;
  localparam logic [4:0] ADEX_REG_EP = 5'h04;
  localparam logic [4:0] ADEX_REG_SIZE = 5'h08;
  localparam logic [4:0] ADEX_REG_BUF = 5'h0c;
  localparam logic [4:0] ADEX_REG_STAT = 5'h10;
  localparam logic [4:0] ADEX_REG_DW3 = 5'h14;
  localparam logic [4:0] ADEX_REG_SKIP = 5'h18;
  localparam logic [4:0] ADEX_REG_FINAL = 5'h1c;
  // commands in the control register
  localparam logic [1:0] ADEX_CMD_LAUNCH = 2'h0;
  localparam logic [1:0] ADEX_CMD_READ = 2'h1;
  localparam logic [1:0] ADEX_CMD_CONT = 2'h2;
  localparam logic [1:0] ADEX_CMD_SCHED = 2'h3;
  // control register fields
  localparam int ADEX_CTRL_GO = 0;
  localparam int ADEX_CTRL_CMD = 1;
  localparam int ADEX_CTRL_SLOT = 4;
  localparam int ADEX_CTRL_BREN = 9;
  localparam int ADEX_CTRL_BRIDX = 10;
  // device-side memory map
  localparam logic [15:0] ADEX_DESC_BASE = 16'h0c00;
  localparam logic [15:0] ADEX_SKIP_ADDR = 16'h0154;
  localparam logic [15:0] ADEX_FINAL_ADDR = 16'h0158;
  localparam logic [18:0] ADEX_BUF_BIAS = 19'h00400;
  // descriptor word fields, bit numbers inside each 32-bit word
  localparam int ADEX_W0_VALID = 0;
  localparam int ADEX_W0_BREQ = 3;
  localparam int ADEX_W0_MAXP = 18;
  localparam int ADEX_W0_PPP = 29;
  localparam int ADEX_W0_EP0 = 31;
  localparam int ADEX_W1_EPHI = 0;
  localparam int ADEX_W1_FA = 3;
  localparam int ADEX_W1_PID = 10;
  localparam int ADEX_W1_CAT = 12;
  localparam int ADEX_W1_SPLIT = 14;
  localparam int ADEX_W2_BOFF = 8;
  localparam int ADEX_W2_RELOAD = 25;
  localparam int ADEX_W3_MOVED = 0;
  localparam int ADEX_W3_NAK = 19;
  localparam int ADEX_W3_RETRY = 23;
  localparam int ADEX_W3_TOGGLE = 25;
  localparam int ADEX_W3_PING = 26;
  localparam int ADEX_W3_XERR = 28;
  localparam int ADEX_W3_BABBLE = 29;
  localparam int ADEX_W3_ACTIVE = 31;
  localparam int ADEX_W4_BRIDX = 0;
  localparam int ADEX_W4_BREN = 5;
  // codes software must not write, and the highest descriptor word number
  localparam logic [1:0] ADEX_PID_PING = 2'h3;
  localparam logic [1:0] ADEX_PPP_UNDEF = 2'h0;
  localparam logic [2:0] ADEX_LAST_WORD = 3'h7;

  // one descriptor's worth of software settings
  typedef struct packed {
    logic split;
    logic [1:0] cat;
    logic [1:0] pid;
    logic [6:0] fa;
    logic [3:0] ep;
    logic [1:0] ppp;
    logic [1:0] retry;
    logic [3:0] reload;
    logic toggle;
    logic [10:0] maxp;
    logic [14:0] breq;
    logic [15:0] boff;
    logic br_en;
    logic [4:0] br_idx;
  } adex_cfg_type;

  // states of the launcher sequencer
  typedef enum logic [3:0] {
    ADEX_ST_IDLE = 4'b0001,
    ADEX_ST_READ = 4'b0010,
    ADEX_ST_WRITE = 4'b0100,
    ADEX_ST_SCHED = 4'b1000
  } adex_state_type;
endpackage : adex_pkg

// ### verilog/adex_word_pack.sv
// composes one 32-bit word of a bulk/control transfer descriptor
`timescale 1ns/1ns
module adex_word_pack
  import adex_pkg::*;
(
  input wire adex_cfg_type cfg_in, // settings of the descriptor
  input wire logic toggle_in, // toggle to load
  input wire logic ping_in, // ping state to load
  input wire logic [2:0] idx_in, // word number 0..7
  output logic [31:0] word_out // composed word
);
  // every word starts from zero so reserved bits are written as zero
  always_comb begin
    word_out = 32'h0000_0000;
    case (idx_in)
      3'h0: begin
        word_out[ADEX_W0_VALID] = 1'b1;
        word_out[ADEX_W0_BREQ +: 15] = cfg_in.breq;
        word_out[ADEX_W0_MAXP +: 11] = cfg_in.maxp;
        word_out[ADEX_W0_PPP +: 2] = cfg_in.ppp;
        word_out[ADEX_W0_EP0] = cfg_in.ep[0];
      end
      3'h1: begin
        word_out[ADEX_W1_EPHI +: 3] = cfg_in.ep[3:1];
        word_out[ADEX_W1_FA +: 7] = cfg_in.fa;
        word_out[ADEX_W1_PID +: 2] = cfg_in.pid;
        word_out[ADEX_W1_CAT +: 2] = cfg_in.cat;
        word_out[ADEX_W1_SPLIT] = cfg_in.split;
      end
      3'h2: begin
        word_out[ADEX_W2_BOFF +: 16] = cfg_in.boff;
        word_out[ADEX_W2_RELOAD +: 4] = cfg_in.reload;
      end
      3'h3: begin
        // moved count and error flag go out as zero
        word_out[ADEX_W3_NAK +: 4] = cfg_in.reload;
        word_out[ADEX_W3_RETRY +: 2] = cfg_in.retry;
        word_out[ADEX_W3_TOGGLE] = toggle_in;
        word_out[ADEX_W3_PING] = ping_in;
        word_out[ADEX_W3_XERR] = 1'b0;
        word_out[ADEX_W3_ACTIVE] = 1'b1;
      end
      3'h4: begin
        word_out[ADEX_W4_BRIDX +: 5] = cfg_in.br_idx;
        word_out[ADEX_W4_BREN] = cfg_in.br_en;
      end
      default: begin
        word_out = 32'h0000_0000; // upper words are reserved
      end
    endcase
  end
endmodule : adex_word_pack

// ### verilog/adex_launcher.sv
// software-driven launcher that builds transfer descriptors in device memory
//
// Design decisions made here: the Avalon-MM register port and the placing of the registers.
`timescale 1ns/1ns
module adex_launcher
  import adex_pkg::*;
(
  input wire logic clk_in, // 10 MHz system clock
  input wire logic arst_n_in, // asynchronous reset, active low
  input wire logic [4:0] avs_address_in, // byte address of register
  input wire logic avs_read_in, // avalon read
  input wire logic avs_write_in, // avalon write
  input wire logic [31:0] avs_writedata_in, // avalon write data
  output logic [31:0] avs_readdata_out, // avalon read data
  output logic avs_waitrequest_out, // avalon wait
  output logic dev_req_out, // device access request, held until ack
  output logic dev_we_out, // 1 write, 0 read
  output logic [15:0] dev_addr_out, // device byte address
  output logic [31:0] dev_wdata_out, // device write data
  input wire logic [31:0] dev_rdata_in, // device read data, valid with ack
  input wire logic dev_ack_in // device accepted the access
);
  // device address of word n of a descriptor slot, used by read and write
  function automatic logic [15:0] desc_addr(input logic [4:0] slot, input logic [2:0] n);
    desc_addr = ADEX_DESC_BASE + {6'h00, slot, n, 2'h0};
  endfunction : desc_addr

  adex_state_type state_ff, nxt_state; // sequencer state
  logic resp_ff; // second cycle of an avalon access
  logic [31:0] rdata_ff; // registered read data
  logic [31:0] ep_ff; // endpoint settings register
  logic [31:0] size_ff; // sizes register
  logic [18:0] buf_ff; // cpu address of payload
  logic [31:0] skip_ff; // skip map to program
  logic [4:0] final_ff; // final slot to program
  logic [1:0] cmd_ff; // command in progress
  logic [4:0] slot_ff; // slot in progress
  logic br_en_ff; // branch enable of the launch
  logic [4:0] br_idx_ff; // branch target of the launch
  logic err_ff; // sticky refusal flag
  logic [31:0] dw3_ff; // last status word read back
  logic toggle_ff; // toggle to write
  logic ping_ff; // ping state to write
  logic [2:0] idx_ff; // word counter
  logic req_ff; // request level
  logic we_ff; // request direction
  logic [15:0] addr_ff; // request address
  logic [31:0] wdata_ff; // request data

  wire busy = (state_ff != ADEX_ST_IDLE); // sequencer at work
  wire acc = (avs_read_in | avs_write_in) & ~resp_ff; // first cycle of access
  wire wr_take = avs_write_in & resp_ff; // write takes effect here
  wire cfg_wr = wr_take & ~busy; // settings frozen while busy
  wire go = cfg_wr & (avs_address_in == ADEX_REG_CTRL) & avs_writedata_in[ADEX_CTRL_GO];
  wire [1:0] go_cmd = avs_writedata_in[ADEX_CTRL_CMD +: 2]; // command written
  wire ack = req_ff & dev_ack_in; // device took the access
  wire [18:0] buf_rel = buf_ff - ADEX_BUF_BIAS; // offset into device ram
  wire [31:0] status = {1'b0, dw3_ff[ADEX_W3_MOVED +: 15], 1'b0, dw3_ff[ADEX_W3_RETRY +: 2],
                        dw3_ff[ADEX_W3_TOGGLE], dw3_ff[ADEX_W3_PING], dw3_ff[ADEX_W3_XERR],
                        dw3_ff[ADEX_W3_BABBLE], dw3_ff[ADEX_W3_ACTIVE], 6'h00, err_ff, busy};

  wire adex_cfg_type cfg; // assembled settings
  assign cfg.split = ep_ff[15];
  assign cfg.cat = ep_ff[14:13];
  assign cfg.pid = ep_ff[12:11];
  assign cfg.fa = ep_ff[6:0];
  assign cfg.ep = ep_ff[10:7];
  assign cfg.ppp = ep_ff[17:16];
  assign cfg.retry = ep_ff[19:18];
  assign cfg.reload = ep_ff[23:20];
  assign cfg.toggle = ep_ff[24];
  assign cfg.maxp = size_ff[26:16];
  assign cfg.breq = size_ff[14:0];
  assign cfg.boff = buf_rel[18:3];
  assign cfg.br_en = br_en_ff;
  assign cfg.br_idx = br_idx_ff;

  // settings that would break the device's traversal or decoding are refused
  wire bad_ppp = (cfg.ppp == ADEX_PPP_UNDEF);
  wire bad_pid = (cfg.pid == ADEX_PID_PING);
  wire bad_buf = (buf_ff < ADEX_BUF_BIAS);
  // judge a launch by its own branch
  wire br_en_new = go ? avs_writedata_in[ADEX_CTRL_BREN] : br_en_ff;
  wire [4:0] br_idx_new = go ? avs_writedata_in[ADEX_CTRL_BRIDX +: 5] : br_idx_ff;
  wire bad_last = br_en_new & (br_idx_new >= final_ff);
  wire bad_skip = br_en_new & skip_ff[br_idx_new];
  wire bad_desc = bad_ppp | bad_pid | bad_buf | bad_last | bad_skip;

  // word to send next: descending order so the valid word lands last
  wire [2:0] pk_idx = (state_ff == ADEX_ST_WRITE) ? idx_ff - 3'h1 : ADEX_LAST_WORD;
  wire [31:0] pk_word; // composed descriptor word
  wire pk_toggle = (state_ff == ADEX_ST_READ) ? dev_rdata_in[ADEX_W3_TOGGLE] : toggle_ff;
  wire pk_ping = (state_ff == ADEX_ST_READ) ? dev_rdata_in[ADEX_W3_PING] : ping_ff;

  adex_word_pack u_pack (
    .cfg_in(cfg),
    .toggle_in(pk_toggle),
    .ping_in(pk_ping),
    .idx_in(pk_idx),
    .word_out(pk_word)
  );

  // avalon read mux, unmapped offsets read zero
  logic [31:0] rd_mux;
  always_comb begin
    case (avs_address_in)
      ADEX_REG_CTRL: rd_mux = {17'h00000, br_idx_ff, br_en_ff, slot_ff, 1'b0, cmd_ff, 1'b0};
      ADEX_REG_EP: rd_mux = ep_ff;
      ADEX_REG_SIZE: rd_mux = size_ff;
      ADEX_REG_BUF: rd_mux = {13'h0000, buf_ff};
      ADEX_REG_STAT: rd_mux = status;
      ADEX_REG_DW3: rd_mux = dw3_ff;
      ADEX_REG_SKIP: rd_mux = skip_ff;
      ADEX_REG_FINAL: rd_mux = {27'h0000000, final_ff};
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // every access waits exactly one cycle, answer in the second
  assign avs_waitrequest_out = acc;
  assign avs_readdata_out = rdata_ff;
  assign dev_req_out = req_ff;
  assign dev_we_out = we_ff;
  assign dev_addr_out = addr_ff;
  assign dev_wdata_out = wdata_ff;

  // avalon response timing and read data capture
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      resp_ff <= 1'b0;
      rdata_ff <= 32'h0000_0000;
    end else begin
      resp_ff <= acc;
      if (acc) begin
        rdata_ff <= rd_mux;
      end
    end
  end

  // software settings; refused while the sequencer owns them
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      ep_ff <= 32'h0001_0000;
      size_ff <= 32'h0000_0000;
      buf_ff <= ADEX_BUF_BIAS;
      skip_ff <= 32'h0000_0000;
      final_ff <= 5'h1f;
    end else if (cfg_wr) begin
      case (avs_address_in)
        ADEX_REG_EP: ep_ff <= avs_writedata_in;
        ADEX_REG_SIZE: size_ff <= avs_writedata_in;
        ADEX_REG_BUF: buf_ff <= avs_writedata_in[18:0];
        ADEX_REG_SKIP: skip_ff <= avs_writedata_in;
        ADEX_REG_FINAL: final_ff <= avs_writedata_in[4:0];
        default: begin
        end
      endcase
    end
  end

  // command latch and sticky refusal flag; a refusal wins over the clear
  wire refuse_now = ((state_ff == ADEX_ST_IDLE) & go & (go_cmd == ADEX_CMD_LAUNCH)
                     | (state_ff == ADEX_ST_READ) & ack & (cmd_ff == ADEX_CMD_CONT))
                    & bad_desc;
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      cmd_ff <= ADEX_CMD_LAUNCH;
      slot_ff <= 5'h00;
      br_en_ff <= 1'b0;
      br_idx_ff <= 5'h00;
      err_ff <= 1'b0;
    end else begin
      if (go) begin
        cmd_ff <= go_cmd;
        slot_ff <= avs_writedata_in[ADEX_CTRL_SLOT +: 5];
        br_en_ff <= avs_writedata_in[ADEX_CTRL_BREN];
        br_idx_ff <= avs_writedata_in[ADEX_CTRL_BRIDX +: 5];
      end
      if (refuse_now) begin
        err_ff <= 1'b1;
      end else if (go) begin
        err_ff <= 1'b0;
      end
    end
  end

  // next state of the sequencer
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      ADEX_ST_IDLE: begin
        if (go && (go_cmd == ADEX_CMD_SCHED)) begin
          nxt_state = ADEX_ST_SCHED;
        end else if (go && (go_cmd != ADEX_CMD_LAUNCH)) begin
          nxt_state = ADEX_ST_READ;
        end else if (go && !bad_desc) begin
          nxt_state = ADEX_ST_WRITE;
        end
      end
      ADEX_ST_READ: begin
        if (ack) begin
          nxt_state = (cmd_ff == ADEX_CMD_CONT && !bad_desc) ? ADEX_ST_WRITE : ADEX_ST_IDLE;
        end
      end
      ADEX_ST_WRITE, ADEX_ST_SCHED: begin
        if (ack && idx_ff == 3'h0) begin
          nxt_state = ADEX_ST_IDLE;
        end
      end
      default: nxt_state = ADEX_ST_IDLE;
    endcase
  end

  // device request: held with address and data until the device acks
  wire start_wr = (nxt_state == ADEX_ST_WRITE) & (state_ff != ADEX_ST_WRITE);
  wire start_rd = (nxt_state == ADEX_ST_READ) & (state_ff == ADEX_ST_IDLE);
  wire start_sc = (nxt_state == ADEX_ST_SCHED) & (state_ff == ADEX_ST_IDLE);
  wire step = ack & (idx_ff != 3'h0) & ((state_ff == ADEX_ST_WRITE) | (state_ff == ADEX_ST_SCHED));
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      state_ff <= ADEX_ST_IDLE;
      req_ff <= 1'b0;
      we_ff <= 1'b0;
      idx_ff <= 3'h0;
      addr_ff <= 16'h0000;
      wdata_ff <= 32'h0000_0000;
    end else begin
      state_ff <= nxt_state;
      if (start_rd) begin
        req_ff <= 1'b1;
        we_ff <= 1'b0;
        addr_ff <= desc_addr(avs_writedata_in[ADEX_CTRL_SLOT +: 5], 3'h3);
      end else if (start_wr) begin
        req_ff <= 1'b1;
        we_ff <= 1'b1;
        idx_ff <= ADEX_LAST_WORD;
        addr_ff <= desc_addr(go ? avs_writedata_in[ADEX_CTRL_SLOT +: 5] : slot_ff,
                             ADEX_LAST_WORD);
        wdata_ff <= pk_word;
      end else if (start_sc) begin
        req_ff <= 1'b1;
        we_ff <= 1'b1;
        idx_ff <= 3'h1;
        addr_ff <= ADEX_SKIP_ADDR;
        wdata_ff <= skip_ff;
      end else if (step && state_ff == ADEX_ST_SCHED) begin
        idx_ff <= 3'h0;
        addr_ff <= ADEX_FINAL_ADDR;
        wdata_ff <= {27'h0000000, final_ff};
      end else if (step) begin
        idx_ff <= pk_idx;
        addr_ff <= desc_addr(slot_ff, pk_idx);
        wdata_ff <= pk_word;
      end else if (ack) begin
        req_ff <= 1'b0;
      end
    end
  end

  // toggle and ping for the next launch; continuation copies device values
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      toggle_ff <= 1'b0;
      ping_ff <= 1'b0;
      dw3_ff <= 32'h0000_0000;
    end else begin
      if (go && go_cmd == ADEX_CMD_LAUNCH) begin
        toggle_ff <= cfg.toggle;
        ping_ff <= 1'b0;
      end else if (state_ff == ADEX_ST_READ && ack) begin
        dw3_ff <= dev_rdata_in;
        toggle_ff <= dev_rdata_in[ADEX_W3_TOGGLE];
        ping_ff <= dev_rdata_in[ADEX_W3_PING];
      end
    end
  end
endmodule : adex_launcher

// ### test/adex_launcher_asserts.sv
// port checker of the descriptor launcher, bound to its top module
`timescale 1ns/1ns
module adex_launcher_asserts
  import adex_pkg::*;
(
  input wire logic clk_in, // system clock
  input wire logic arst_n_in, // async reset, active low
  input wire logic avs_read_in, // avalon read
  input wire logic avs_write_in, // avalon write
  input wire logic avs_waitrequest_out, // avalon wait
  input wire logic dev_req_out, // device request
  input wire logic dev_we_out, // device write
  input wire logic [15:0] dev_addr_out, // device address
  input wire logic [31:0] dev_wdata_out, // device write data
  input wire logic [31:0] dev_rdata_in, // device read data
  input wire logic dev_ack_in // device ack
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!arst_n_in);
  wire desc_hit = dev_addr_out[15:10] == 6'h03; // descriptor region
  wire [2:0] word = dev_addr_out[4:2]; // word inside a slot
  wire dwr = dev_req_out && dev_we_out && desc_hit; // descriptor write
  wire rd3 = dev_req_out && dev_ack_in && !dev_we_out && desc_hit && word == 3'h3;
  logic cont_ff; // a continuation is in flight
  logic [1:0] cap_ff; // ping and toggle read back
  logic [3:0] nak_ff; // countdown written into word 3
  // req stays high through a continuation, so a low req ends one
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      cont_ff <= 1'b0;
      cap_ff <= 2'h0;
      nak_ff <= 4'h0;
    end else begin
      if (rd3) begin
        cont_ff <= 1'b1;
        cap_ff <= dev_rdata_in[26:25];
      end else if (!dev_req_out) begin
        cont_ff <= 1'b0;
      end
      if (dwr && dev_ack_in && word == 3'h3) begin
        nak_ff <= dev_wdata_out[22:19];
      end
    end
  end
  property p_wait;
    $rose(avs_read_in || avs_write_in) |-> avs_waitrequest_out ##1 !avs_waitrequest_out;
  endproperty
  a_wait: assert property (p_wait) else $error("avalon access not answered in one wait");
  property p_hold;
    dev_req_out && !dev_ack_in |=> dev_req_out && $stable(dev_addr_out) &&
      $stable(dev_we_out) && $stable(dev_wdata_out);
  endproperty
  a_hold: assert property (p_hold) else $error("device request changed before ack");
  property p_order;
    dwr && dev_ack_in && word != 3'h0 |=> dwr && dev_addr_out == $past(dev_addr_out) - 16'h4;
  endproperty
  a_order: assert property (p_order) else $error("descriptor words out of order");
  property p_last;
    dwr && dev_ack_in && word == 3'h0 |-> dev_wdata_out[0] ##1 !dev_req_out;
  endproperty
  a_last: assert property (p_last) else $error("valid word not written last");
  property p_pid;
    dwr && word == 3'h1 |-> dev_wdata_out[11:10] != ADEX_PID_PING;
  endproperty
  a_pid: assert property (p_pid) else $error("ping token written");
  property p_ppp;
    dwr && word == 3'h0 |-> dev_wdata_out[30:29] != ADEX_PPP_UNDEF;
  endproperty
  a_ppp: assert property (p_ppp) else $error("packets per pass zero");
  property p_w3;
    dwr && word == 3'h3 |-> dev_wdata_out[31] && !dev_wdata_out[28];
  endproperty
  a_w3: assert property (p_w3) else $error("status word not active or error set");
  property p_nak;
    dwr && word == 3'h2 |-> dev_wdata_out[28:25] == nak_ff;
  endproperty
  a_nak: assert property (p_nak) else $error("reload differs from countdown");
  property p_ping;
    dwr && word == 3'h3 |-> dev_wdata_out[26] == (cont_ff && cap_ff[1]);
  endproperty
  a_ping: assert property (p_ping) else $error("ping state wrong");
  property p_toggle;
    dwr && word == 3'h3 && cont_ff |-> dev_wdata_out[25] == cap_ff[0];
  endproperty
  a_toggle: assert property (p_toggle) else $error("toggle not copied");
  c_launch: cover property (dwr && dev_ack_in && word == 3'h0 && !cont_ff);
  c_cont: cover property (dwr && dev_ack_in && word == 3'h0 && cont_ff);
  c_stall: cover property (dev_req_out && !dev_ack_in ##1 dev_ack_in);
endmodule : adex_launcher_asserts

bind adex_launcher adex_launcher_asserts u_chk (.clk_in(clk_in), .arst_n_in(arst_n_in),
  .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
  .avs_waitrequest_out(avs_waitrequest_out), .dev_req_out(dev_req_out),
  .dev_we_out(dev_we_out), .dev_addr_out(dev_addr_out), .dev_wdata_out(dev_wdata_out),
  .dev_rdata_in(dev_rdata_in), .dev_ack_in(dev_ack_in));

// ### test/adex_dev_model.sv
// behavioural device: descriptor memory with a delayed acknowledge
`timescale 1ns/1ns
module adex_dev_model (
  input wire logic clk_in, // system clock
  input wire logic arst_n_in, // async reset, active low
  input wire logic [3:0] delay_in, // ack latency in cycles
  input wire logic req_in, // access request
  input wire logic we_in, // 1 write
  input wire logic [15:0] addr_in, // byte address
  input wire logic [31:0] wdata_in, // write data
  output logic [31:0] rdata_out, // read data
  output logic ack_out // access accepted
);
  logic [31:0] mem [0:255]; // 32 slots of 8 words, no reset like real ram
  logic [31:0] skip_ff; // skip map
  logic [4:0] final_ff; // final slot marker
  logic [3:0] cnt_ff; // wait counter
  logic [31:0] last_ff; // last word read
  wire [7:0] widx = addr_in[9:2]; // word index
  wire [7:0] sidx = {widx[7:3], 3'h3}; // status word of the slot
  wire [31:0] st = mem[sidx]; // current status word
  wire skip_a = addr_in == 16'h0154; // skip map address
  wire fin_a = addr_in == 16'h0158; // final marker address
  wire [31:0] rd_word = skip_a ? skip_ff : fin_a ? {27'h0, final_ff} : mem[widx];
  // only an active descriptor given a valid word 0 runs
  wire run = we_in && widx[2:0] == 3'h0 && wdata_in[0] && st[31];
  assign ack_out = req_in && cnt_ff == delay_in;
  // a released bus shows the inverse of the last word, never a stale copy
  assign rdata_out = (ack_out && !we_in) ? rd_word : ~last_ff;
  // memory, markers and the completed transfer's status
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      cnt_ff <= 4'h0;
      last_ff <= 32'h0;
      skip_ff <= 32'h0;
      final_ff <= 5'h1f;
    end else begin
      cnt_ff <= (req_in && !ack_out) ? cnt_ff + 4'h1 : 4'h0;
      if (ack_out && !we_in) begin
        last_ff <= rd_word;
      end
      if (ack_out && we_in) begin
        if (skip_a) begin
          skip_ff <= wdata_in;
        end else if (fin_a) begin
          final_ff <= wdata_in[4:0];
        end else if (run) begin
          mem[widx] <= {wdata_in[31:1], 1'b0};
          mem[sidx] <= {1'b0, st[30:27], 1'b1, ~st[25], st[24:15], wdata_in[17:3]};
        end else begin
          mem[widx] <= wdata_in;
        end
      end
    end
  end
endmodule : adex_dev_model

// ### test/adex_launcher_tb.sv
// self-checking bench of the descriptor launcher against a device model
`timescale 1ns/1ns
module adex_launcher_tb
  import adex_pkg::*;
;
  logic clk_in = 1'b0; // 10 MHz clock
  logic arst_n_in = 1'b0; // reset, active low
  logic [4:0] avs_address_in = 5'h0; // register address
  logic avs_read_in = 1'b0; // avalon read
  logic avs_write_in = 1'b0; // avalon write
  logic [31:0] avs_writedata_in = 32'h0; // write data
  logic [31:0] avs_readdata_out; // read data
  logic avs_waitrequest_out; // wait
  logic dev_req_out; // device request
  logic dev_we_out; // device write
  logic [15:0] dev_addr_out; // device address
  logic [31:0] dev_wdata_out; // device write data
  logic [31:0] dev_rdata_in; // device read data
  logic dev_ack_in; // device ack
  logic [3:0] delay = 4'h0; // device latency, changed between commands
  logic [31:0] seed = 32'hab6c; // xorshift state
  logic [31:0] rq; // last read word
  logic [31:0] exp_q[$]; // expected read data
  logic [31:0] msk_q[$]; // bits compared, zero for polls
  int mismatches = 0;
  int total_checks = 0;
  int cyc = 0;
  always #50 clk_in = ~clk_in;
  adex_launcher dut (.clk_in(clk_in), .arst_n_in(arst_n_in), .avs_address_in(avs_address_in),
    .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
    .avs_writedata_in(avs_writedata_in), .avs_readdata_out(avs_readdata_out),
    .avs_waitrequest_out(avs_waitrequest_out), .dev_req_out(dev_req_out),
    .dev_we_out(dev_we_out), .dev_addr_out(dev_addr_out), .dev_wdata_out(dev_wdata_out),
    .dev_rdata_in(dev_rdata_in), .dev_ack_in(dev_ack_in));
  adex_dev_model u_dev (.clk_in(clk_in), .arst_n_in(arst_n_in), .delay_in(delay),
    .req_in(dev_req_out), .we_in(dev_we_out), .addr_in(dev_addr_out),
    .wdata_in(dev_wdata_out), .rdata_out(dev_rdata_in), .ack_out(dev_ack_in));
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs
  function automatic logic [31:0] ctl(logic [1:0] c, logic [4:0] s, logic e, logic [4:0] x);
    return {17'h0, x, e, s, 1'b0, c, 1'b1};
  endfunction : ctl
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : stop_test
  // one avalon access: held until waitrequest is seen low at an edge
  task automatic av_acc(input logic wr, input logic [4:0] a, input logic [31:0] d);
    @(posedge clk_in);
    avs_address_in <= a;
    avs_writedata_in <= d;
    avs_write_in <= wr;
    avs_read_in <= ~wr;
    do begin
      @(posedge clk_in);
    end while (avs_waitrequest_out !== 1'b0);
    rq = avs_readdata_out;
    avs_write_in <= 1'b0;
    avs_read_in <= 1'b0;
  endtask : av_acc
  task automatic av_rd(input logic [4:0] a, input logic [31:0] e, input logic [31:0] m);
    exp_q.push_back(e);
    msk_q.push_back(m);
    av_acc(1'b0, a, 32'h0);
  endtask : av_rd
  // poll busy under a bound, the device may stall each word
  task automatic idle();
    int n;
    n = 0;
    do begin
      av_rd(ADEX_REG_STAT, 32'h0, 32'h0);
      n++;
    end while (rq[0] !== 1'b0 && n < 100);
    if (n >= 100) chk("busy", rq, 32'h0);
  endtask : idle
  // scoreboard: each completed read takes the oldest note
  always @(negedge clk_in) begin
    if (avs_read_in && avs_waitrequest_out === 1'b0 && exp_q.size() > 0) begin
      if (msk_q[0] != 32'h0) chk($sformatf("reg %h", avs_address_in),
        avs_readdata_out & msk_q[0], exp_q[0] & msk_q[0]);
      void'(exp_q.pop_front());
      void'(msk_q.pop_front());
    end
  end
  // hang guard
  always @(posedge clk_in) begin
    cyc++;
    if (cyc == 40000) begin
      mismatches++;
      stop_test();
    end
  end
  initial begin
    logic [31:0] r, ep, sz, bf, w3;
    logic [31:0] b_ep [5] = '{32'h0, 32'h1_1800, 32'h1_0000, 32'h1_0000, 32'h1_0000};
    logic [31:0] b_bf [5] = '{32'h400, 32'h400, 32'h3f8, 32'h400, 32'h400};
    logic [4:0] b_ix [5] = '{5'h0, 5'h0, 5'h0, 5'h6, 5'h9};
    repeat (5) @(posedge clk_in);
    arst_n_in <= 1'b1;
    av_rd(ADEX_REG_EP, 32'h0001_0000, 32'hffff_ffff);
    av_rd(ADEX_REG_SIZE, 32'h0, 32'hffff_ffff);
    av_rd(ADEX_REG_BUF, 32'h400, 32'hffff_ffff);
    av_rd(ADEX_REG_STAT, 32'h0, 32'hffff_ffff);
    av_rd(5'h01, 32'h0, 32'hffff_ffff);
    av_acc(1'b1, ADEX_REG_SKIP, 32'h40);
    av_acc(1'b1, ADEX_REG_FINAL, 32'h8);
    av_acc(1'b1, ADEX_REG_CTRL, ctl(ADEX_CMD_SCHED, 5'h0, 1'b0, 5'h0));
    idle();
    chk("dev skip", u_dev.skip_ff, 32'h40);
    chk("dev final", {27'h0, u_dev.final_ff}, 32'h8);
    for (int i = 0; i < 5; i++) begin
      av_acc(1'b1, ADEX_REG_EP, b_ep[i]);
      av_acc(1'b1, ADEX_REG_BUF, b_bf[i]);
      av_acc(1'b1, ADEX_REG_CTRL, ctl(ADEX_CMD_LAUNCH, 5'h1, i > 2, b_ix[i]));
      idle();
      av_rd(ADEX_REG_STAT, 32'h2, 32'h3);
    end
    for (int i = 0; i < 4; i++) begin
      r = xs();
      ep = {7'h0, r[24:18], (r[17:16] == 2'h0) ? 2'h1 : r[17:16], r[15], r[14], 1'b0,
        (r[12:11] == 2'h3) ? 2'h2 : r[12:11], r[10:0]};
      r = xs();
      sz = {7'h0, r[24:16], 1'b0, r[14:0]};
      bf = 32'h400 + {16'h0, r[31:19], 3'h0};
      delay <= (i == 0) ? 4'h0 : {1'b0, r[2:0]};
      av_acc(1'b1, ADEX_REG_EP, ep);
      av_acc(1'b1, ADEX_REG_SIZE, sz);
      av_acc(1'b1, ADEX_REG_BUF, bf);
      av_acc(1'b1, ADEX_REG_CTRL, ctl(ADEX_CMD_LAUNCH, i[4:0], i[0], 5'h7));
      av_acc(1'b1, ADEX_REG_SIZE, ~sz);
      idle();
      av_rd(ADEX_REG_STAT, 32'h0, 32'h3);
      chk("w1", u_dev.mem[{i[4:0], 3'h1}], {17'h0, ep[15:11], ep[6:0], ep[10:8]});
      chk("w2", u_dev.mem[{i[4:0], 3'h2}],
        {3'h0, ep[23:20], 1'b0, bf[18:3] - 16'h0080, 8'h0});
      chk("w4", u_dev.mem[{i[4:0], 3'h4}], {26'h0, i[0], 5'h7});
      av_rd(ADEX_REG_SIZE, sz, 32'hffff_ffff);
      av_acc(1'b1, ADEX_REG_CTRL, ctl(ADEX_CMD_READ, i[4:0], 1'b0, 5'h0));
      idle();
      w3 = {5'h0, 1'b1, ~ep[24], ep[19:18], ep[23:20], 4'h0, sz[14:0]};
      av_rd(ADEX_REG_DW3, w3, 32'hffff_ffff);
      av_rd(ADEX_REG_STAT, {1'b0, sz[14:0], 1'b0, ep[19:18], ~ep[24], 12'h800},
        32'hffff_ffff);
      av_acc(1'b1, ADEX_REG_CTRL, ctl(ADEX_CMD_CONT, i[4:0], i[0], 5'h7));
      idle();
      av_acc(1'b1, ADEX_REG_CTRL, ctl(ADEX_CMD_READ, i[4:0], 1'b0, 5'h0));
      idle();
      w3[25] = ep[24];
      av_rd(ADEX_REG_DW3, w3, 32'hffff_ffff);
    end
    stop_test();
  end
endmodule : adex_launcher_tb
